/* File: hdl/sec_ctrl_map.svh */
// Bit positions, reset values and counts for the serial error and mode control slice
// Function
// - Underflow enable bit 9 gates underflow error
// - Format enable bit 8 gates format error
// - Bits 7:6 read zero, writes ignored
// - Bit 5 makes master watch slave select
// - Bit 4 enables gap prescaler, master only
// - Bit 3 role select resets to slave
// - Interrupt enables reset to zero, read/write
// - Overflow enable bit 10 gates overflow error
`ifndef SEC_CTRL_MAP_SVH
`define SEC_CTRL_MAP_SVH
`define SEC_CTRL_W 11
`define SEC_BIT_OVF_IE 10
`define SEC_BIT_UNF_IE 9
`define SEC_BIT_FMT_IE 8
`define SEC_BIT_RSV_HI 7
`define SEC_BIT_RSV_LO 6
`define SEC_BIT_SS_CHK 5
`define SEC_BIT_GAP_PS 4
`define SEC_BIT_ROLE 3
`define SEC_CTRL_RESET 11'h000
`define SEC_CTRL_WMASK 11'h73f
`define SEC_PS_W 4
`define SEC_PS_DIV 4'h3
`endif

/* File: hdl/sec_pkg.sv */
// Types for the serial error and mode control slice
package sec_pkg;
  typedef enum logic [1:0] {
    SEC_SLAVE = 2'b01,
    SEC_MASTER = 2'b10
  } sec_role_t;
endpackage : sec_pkg

/* File: hdl/sec_gap_tick.sv */
// Frame gap tick generator with optional prescaler
`timescale 1ns/1ps
`include "sec_ctrl_map.svh"
module sec_gap_tick (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Control
  input wire logic prescale_on_i,
  // Tick out
  output logic tick_o
);
  logic [`SEC_PS_W-1:0] cnt;

  // Divide by prescaler when enabled, else tick every cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (!prescale_on_i || cnt == `SEC_PS_DIV) begin
        cnt <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
        tick_o <= 1'b0;
      end
    end
  end
endmodule : sec_gap_tick

/* File: hdl/sec_ctrl.sv */
// Serial error interrupt gating and mode control register slice
`timescale 1ns/1ps
`include "sec_ctrl_map.svh"
module sec_ctrl (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Control register write and read
  input wire logic ctrl_we_i,
  input wire logic [`SEC_CTRL_W-1:0] ctrl_wdata_i,
  output logic [`SEC_CTRL_W-1:0] ctrl_rdata_o,
  // Error flags from the shifter
  input wire logic underflow_error_flag_i,
  input wire logic overflow_error_flag_i,
  input wire logic format_error_flag_i,
  // Link pin
  input wire logic slave_select_in_i,
  // Outputs to the serial unit
  output logic serial_error_interrupt_o,
  output logic role_master_o,
  output logic frame_gap_tick_o,
  output logic ss_format_error_o
);
  // Reset image of the control word; each field takes its own bit from it
  localparam logic [`SEC_CTRL_W-1:0] ctrl_reset_val = `SEC_CTRL_RESET;

  // Error sources in lane order: format, underflow, overflow
  localparam int src_n = 3;

  // Position of each lane's enable within the control word
  localparam int src_bit [src_n] = '{`SEC_BIT_FMT_IE, `SEC_BIT_UNF_IE, `SEC_BIT_OVF_IE};

  // Role taken out of reset
  localparam sec_pkg::sec_role_t role_reset =
    ctrl_reset_val[`SEC_BIT_ROLE] ? sec_pkg::SEC_MASTER : sec_pkg::SEC_SLAVE;

  // Error flags and their gating, one lane per source
  logic [src_n-1:0] err_flag;
  wire [src_n-1:0] src_enable;
  wire [src_n-1:0] src_hit;

  // Enable fields under their own names
  logic underflow_irq_enable;
  logic format_error_irq_enable;
  logic overflow_irq_enable;

  // Mode fields
  logic slave_select_check_enable;
  logic frame_gap_prescale_enable;
  logic role_select;

  // Plain storage below the role bit
  logic [`SEC_BIT_ROLE-1:0] spare_bits;

  // Role held as a one-hot state
  sec_pkg::sec_role_t role;
  sec_pkg::sec_role_t next_role;

  // Word as software reads it, before the readback flop
  logic [`SEC_CTRL_W-1:0] ctrl_word;

  // Values headed for the output flops
  logic next_irq;
  logic next_ss_error;
  logic ss_check_live;
  logic gap_prescale_on;
  logic gap_tick;

  // Flags gathered in lane order
  assign err_flag = {overflow_error_flag_i, underflow_error_flag_i, format_error_flag_i};

  // One enable flop and one gate per error source
  for (genvar s = 0; s < src_n; s++) begin : g_src
    logic enable;

    // Enable starts masked and follows each accepted write
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        enable <= ctrl_reset_val[src_bit[s]];
      end else if (ce_i && ctrl_we_i) begin
        enable <= ctrl_wdata_i[src_bit[s]];
      end
    end

    // A flag reaches the interrupt only through its own enable
    assign src_enable[s] = enable;
    assign src_hit[s] = err_flag[s] & enable;
  end

  // Enables named by their source
  assign format_error_irq_enable = src_enable[0];
  assign underflow_irq_enable = src_enable[1];
  assign overflow_irq_enable = src_enable[2];

  // Slave-select watch enable; while clear the pin is ignored
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slave_select_check_enable <= ctrl_reset_val[`SEC_BIT_SS_CHK];
    end else if (ce_i && ctrl_we_i) begin
      slave_select_check_enable <= ctrl_wdata_i[`SEC_BIT_SS_CHK];
    end
  end

  // Frame gap prescaler enable; stored in any role, acts only as master
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_gap_prescale_enable <= ctrl_reset_val[`SEC_BIT_GAP_PS];
    end else if (ce_i && ctrl_we_i) begin
      frame_gap_prescale_enable <= ctrl_wdata_i[`SEC_BIT_GAP_PS];
    end
  end

  // Spare bits: stored and read back, nothing hangs off them
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      spare_bits <= ctrl_reset_val[`SEC_BIT_ROLE-1:0];
    end else if (ce_i && ctrl_we_i) begin
      spare_bits <= ctrl_wdata_i[`SEC_BIT_ROLE-1:0];
    end
  end

  // Written role bit decoded to a state
  always_comb begin
    case (ctrl_wdata_i[`SEC_BIT_ROLE])
      1'b1: next_role = sec_pkg::SEC_MASTER;
      default: next_role = sec_pkg::SEC_SLAVE;
    endcase
  end

  // Role state: slave out of reset, then whatever software writes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      role <= role_reset;
    end else if (ce_i && ctrl_we_i) begin
      role <= next_role;
    end
  end

  // Role state to a plain master flag; a broken code falls back to slave
  always_comb begin
    case (role)
      sec_pkg::SEC_MASTER: role_select = 1'b1;
      sec_pkg::SEC_SLAVE: role_select = 1'b0;
      default: role_select = 1'b0;
    endcase
  end

  // Readback word; positions 7:6 are never filled
  always_comb begin
    ctrl_word = '0;
    ctrl_word[`SEC_BIT_OVF_IE] = overflow_irq_enable;
    ctrl_word[`SEC_BIT_UNF_IE] = underflow_irq_enable;
    ctrl_word[`SEC_BIT_FMT_IE] = format_error_irq_enable;
    ctrl_word[`SEC_BIT_SS_CHK] = slave_select_check_enable;
    ctrl_word[`SEC_BIT_GAP_PS] = frame_gap_prescale_enable;
    ctrl_word[`SEC_BIT_ROLE] = role_select;
    ctrl_word[`SEC_BIT_ROLE-1:0] = spare_bits;
  end

  // Readback from a flop; the mask keeps 7:6 at zero whatever is stored
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_rdata_o <= '0;
    end else if (ce_i) begin
      ctrl_rdata_o <= ctrl_word & `SEC_CTRL_WMASK;
    end
  end

  // Enabled sources ORed onto one interrupt
  assign next_irq = |src_hit;

  // Pin watch only counts in master mode with the check enabled
  assign ss_check_live = role_select & slave_select_check_enable;
  assign next_ss_error = ss_check_live & slave_select_in_i;

  // Prescaler gated by role so a slave never stretches its gaps
  assign gap_prescale_on = frame_gap_prescale_enable & role_select;

  // Interrupt output; a level that follows flags one cycle late
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_error_interrupt_o <= 1'b0;
    end else if (ce_i) begin
      serial_error_interrupt_o <= next_irq;
    end
  end

  // Role output for the serial unit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      role_master_o <= 1'b0;
    end else if (ce_i) begin
      role_master_o <= role_select;
    end
  end

  // Format error raised by the select pin while master
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ss_format_error_o <= 1'b0;
    end else if (ce_i) begin
      ss_format_error_o <= next_ss_error;
    end
  end

  // Gap tick retimed so the output comes straight from a flop
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_gap_tick_o <= 1'b0;
    end else if (ce_i) begin
      frame_gap_tick_o <= gap_tick;
    end
  end

  // Prescaler applies only in master mode
  sec_gap_tick u_gap (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .prescale_on_i(gap_prescale_on),
    .tick_o(gap_tick)
  );
endmodule : sec_ctrl

/* File: tb/sec_ctrl_properties.sv */
// Checker for the serial error and mode control slice
`timescale 1ns/1ps
module sec_ctrl_properties (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Link pin and error flags
  input wire logic slave_select_in_i,
  input wire logic overflow_error_flag_i,
  input wire logic underflow_error_flag_i,
  input wire logic format_error_flag_i,
  // Watched outputs
  input wire logic role_master_o,
  input wire logic frame_gap_tick_o,
  input wire logic serial_error_interrupt_o,
  input wire logic ss_format_error_o,
  input wire logic [10:0] ctrl_rdata_o
);
  wire [10:0] r = ctrl_rdata_o;
  wire q = serial_error_interrupt_o;
  wire [2:0] f = {overflow_error_flag_i, underflow_error_flag_i, format_error_flag_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Interrupt follows flags gated by enables seen on readback
  AST_UNF: assert property ($past(f[1]) && r[9] |-> q) else $error("unf gate");
  AST_FMT: assert property ($past(f[0]) && r[8] |-> q) else $error("fmt gate");
  AST_OVF: assert property ($past(f[2]) && r[10] |-> q) else $error("ovf gate");
  AST_OR: assert property (q |-> |($past(f) & r[10:8])) else $error("irq cause");
  AST_RSV: assert property (r[7:6] == 2'h0) else $error("rsv bits");
  AST_SS: assert property (ss_format_error_o == (r[5] & r[3] & $past(slave_select_in_i)))
    else $error("ss error");
  AST_GAP: assert property ($past(role_master_o) && role_master_o && r[4] && frame_gap_tick_o
    |=> !frame_gap_tick_o) else $error("gap tick");
  AST_ROLE: assert property (r[3] == role_master_o) else $error("role");
  // A low enable freezes readback, interrupt, role and select error outputs
  AST_FREEZE: assert property (!ce_i |=> $stable(r) && $stable(q) && $stable(role_master_o)
    && $stable(ss_format_error_o)) else $error("freeze");
  AST_RST: assert property ($rose(resetn_i) |-> r == 11'h000 && !q) else $error("rst");
endmodule : sec_ctrl_properties

/* File: tb/sec_peer.sv */
// Serial peer model driving the slave-select line
`timescale 1ns/1ps
module sec_peer (
  input wire logic clk_i,
  input wire logic sel_i,
  output logic slave_select_in_o
);
  // Peer asserts select on the bench's command
  always_ff @(posedge clk_i) slave_select_in_o <= sel_i;
endmodule : sec_peer

/* File: tb/sec_ctrl_tb.sv */
// Self-checking bench for the serial error and mode control slice
`timescale 1ns/1ps
module sec_ctrl_tb;
  logic clk_i = 0, resetn_i = 0, ctrl_we_i = 0, sel = 0, slave_select_in_i, ce_i = 1;
  logic overflow_error_flag_i = 0, underflow_error_flag_i = 0, format_error_flag_i = 0;
  logic serial_error_interrupt_o, role_master_o, frame_gap_tick_o, ss_format_error_o;
  logic [10:0] ctrl_wdata_i = 0, ctrl_rdata_o;
  logic [16:0] r;
  int miscompares = 0, samples_checked = 0, cyc = 0, n;
  // Rows: control word, flags ovf/unf/fmt, select, interrupt, select error
  logic [16:0] rows [9] = '{{11'h200, 3'h2, 3'h2}, {11'h000, 3'h7, 3'h0}, {11'h100, 3'h1, 3'h2},
    {11'h400, 3'h4, 3'h2}, {11'h300, 3'h4, 3'h0}, {11'h02f, 3'h0, 3'h5}, {11'h027, 3'h0, 3'h4},
    {11'h008, 3'h0, 3'h4}, {11'h7ff, 3'h0, 3'h0}};
  sec_ctrl sec_ctrl_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .ctrl_we_i(ctrl_we_i),
    .ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(ctrl_rdata_o),
    .underflow_error_flag_i(underflow_error_flag_i),
    .overflow_error_flag_i(overflow_error_flag_i),
    .format_error_flag_i(format_error_flag_i), .slave_select_in_i(slave_select_in_i),
    .serial_error_interrupt_o(serial_error_interrupt_o), .role_master_o(role_master_o),
    .frame_gap_tick_o(frame_gap_tick_o), .ss_format_error_o(ss_format_error_o));
  sec_peer sec_peer_i (.clk_i, .sel_i(sel), .slave_select_in_o(slave_select_in_i));
  always #12.5 clk_i = ~clk_i;
  // Cycle ceiling cuts a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 500) begin
      miscompares++;
      finish_test();
    end
  end
  task chk(string s, logic [10:0] seen, e);
    samples_checked++;
    if (seen !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, e, seen);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d errors %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Main sequence: table rows, then gap ticks and a mid-run reset
  initial begin
    repeat (2) @(negedge clk_i);
    resetn_i = 1;
    chk("ctrl", ctrl_rdata_o, 11'h000);
    foreach (rows[i]) begin
      r = rows[i];
      @(negedge clk_i);
      {ctrl_wdata_i, overflow_error_flag_i, underflow_error_flag_i, format_error_flag_i} = r[16:3];
      sel = r[2];
      ctrl_we_i = 1;
      @(negedge clk_i);
      ctrl_we_i = 0;
      @(negedge clk_i);
      chk("ctrl", ctrl_rdata_o, r[16:6] & 11'h73f);
      chk("role", role_master_o, r[9]);
      chk("irq", serial_error_interrupt_o, r[1]);
      chk("ss_err", ss_format_error_o, r[0]);
    end
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_i);
      ctrl_wdata_i = k ? 11'h018 : 11'h010;
      ctrl_we_i = 1;
      repeat (3) @(negedge clk_i) ctrl_we_i = 0;
      n = 0;
      repeat (16) @(negedge clk_i) n += frame_gap_tick_o;
      chk("ticks", 11'(n), k ? 11'h004 : 11'h010);
    end
    resetn_i = 0;
    @(negedge clk_i) resetn_i = 1;
    chk("role", role_master_o, 11'h000);
    // Store a word, then write another while the enable is low: it must be lost
    @(negedge clk_i);
    ctrl_wdata_i = 11'h207;
    ctrl_we_i = 1;
    @(negedge clk_i) ctrl_we_i = 0;
    @(negedge clk_i);
    {ce_i, ctrl_we_i, ctrl_wdata_i} = {1'b0, 1'b1, 11'h000};
    repeat (2) @(negedge clk_i);
    chk("frozen", ctrl_rdata_o, 11'h207);
    {ce_i, ctrl_we_i} = 2'b10;
    repeat (2) @(negedge clk_i);
    chk("kept", ctrl_rdata_o, 11'h207);
    finish_test();
  end
endmodule : sec_ctrl_tb
bind sec_ctrl sec_ctrl_properties sec_ctrl_properties_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .slave_select_in_i(slave_select_in_i),
  .overflow_error_flag_i(overflow_error_flag_i),
  .underflow_error_flag_i(underflow_error_flag_i),
  .format_error_flag_i(format_error_flag_i), .role_master_o(role_master_o),
  .frame_gap_tick_o(frame_gap_tick_o), .serial_error_interrupt_o(serial_error_interrupt_o),
  .ss_format_error_o(ss_format_error_o), .ctrl_rdata_o(ctrl_rdata_o));
